// ===== rtl/dcc_defines.vh
// Register offsets, field positions and timing constants of the channel control.
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
`define DCC_CTRL0_OFF      12'h500
`define DCC_STAT0_OFF      12'h504
`define DCC_CTRL1_OFF      12'h580
`define DCC_STAT1_OFF      12'h584
`define DCC_IRQ_STAT_OFF   12'h600
`define DCC_IRQ_EN_OFF     12'h604
`define DCC_IRQ_CLR_OFF    12'h608
`define DCC_ADDR_W         12
`define DCC_ABORT_BIT      27
`define DCC_PAUSE_BIT      26
`define DCC_LAUNCH_BIT     25
`define DCC_STYLE_BIT      23
`define DCC_VFLUSH_BIT     17
`define DCC_PFLUSH_BIT     16
`define DCC_VBURST_LSB     12
`define DCC_VBACK_LSB      8
`define DCC_PBURST_LSB     4
`define DCC_PBACK_LSB      0
`define DCC_ST_ERR_BIT     28
`define DCC_ST_ABORT_BIT   27
`define DCC_ST_PAUSE_BIT   26
`define DCC_ST_DONE_BIT    25
`define DCC_ST_ACTIVE_BIT  24
`define DCC_CTRL_RESET     32'h00000000
`define DCC_BURST_BASE     13'h0020
`define DCC_CLK_MHZ        250
`define DCC_BACKOFF_US     1
`define DCC_CYC_PER_US     (`DCC_CLK_MHZ * `DCC_BACKOFF_US)
`endif

// ===== rtl/dcc_channel_control.v
// Two-channel DMA control registers with abort, launch and interrupt logic.
//
// Implementation choice: register access over APB.
`include "dcc_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module dcc_channel_control #(
    parameter CYC_PER_US = `DCC_CYC_PER_US  // Clock cycles in one microsecond.
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    output reg  [1:0]  master_start,
    output reg  [1:0]  master_halt,
    output reg  [1:0]  fifo_invalidate,
    output wire [1:0]  direct_style,
    output wire [1:0]  vme_flush_on_fault,
    output wire [1:0]  pcix_flush_on_fault,
    output reg  [25:0] burst_bytes,
    output wire [1:0]  backoff_expired,
    input  wire [1:0]  block_request,
    input  wire [1:0]  source_is_vme,
    input  wire [1:0]  transfer_finished,
    input  wire [1:0]  transfer_error,
    input  wire [1:0]  pause_reached,
    output reg  [1:0]  pause_command,
    output wire        irq
);

    // Access strobe: every transfer completes in its access cycle.
    wire        wr_en;
    wire        rd_en;
    wire [11:0] offs;
    // Only the lowest 4 KB page holds registers; other pages are unmapped.
    wire        page_ok;
    // Stored read/write fields of each control register.
    reg  [1:0]  style;
    reg  [1:0]  vflush;
    reg  [1:0]  pflush;
    reg  [5:0]  vburst;
    reg  [5:0]  vback;
    reg  [5:0]  pburst;
    reg  [5:0]  pback;
    // Completion status per channel.
    reg  [1:0]  active;
    reg  [1:0]  done;
    reg  [1:0]  err;
    reg  [1:0]  aborted;
    reg  [1:0]  paused;
    // Interrupt status, enable and clear.
    reg  [1:0]  irq_stat;
    reg  [1:0]  irq_en;
    wire [1:0]  ctrl_hit;
    wire [1:0]  abort_cmd;
    wire [1:0]  launch_cmd;
    wire [1:0]  pause_cmd;
    wire [1:0]  irq_clr;
    wire [1:0]  finish_evt;
    reg  [31:0] ctrl_view [0:1];
    reg  [31:0] stat_view [0:1];

    assign offs    = paddr[11:0];
    assign page_ok = (paddr[31:12] == 20'h00000);
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    // Unmapped or misaligned addresses answer with an error.
    assign pslverr = psel && penable &&
                     !((offs == `DCC_CTRL0_OFF) || (offs == `DCC_STAT0_OFF) ||
                       (offs == `DCC_CTRL1_OFF) || (offs == `DCC_STAT1_OFF) ||
                       (offs == `DCC_IRQ_STAT_OFF) ||
                       (offs == `DCC_IRQ_EN_OFF) ||
                       (offs == `DCC_IRQ_CLR_OFF)) ||
                     (psel && penable && (paddr[31:12] != 20'h00000));

    assign ctrl_hit[0] = wr_en && (paddr[31:12] == 20'h00000) &&
                         (offs == `DCC_CTRL0_OFF);
    assign ctrl_hit[1] = wr_en && (paddr[31:12] == 20'h00000) &&
                         (offs == `DCC_CTRL1_OFF);

    // Command bits live in the top byte, so they need byte lane 3.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_cmd
            assign abort_cmd[g]  = ctrl_hit[g] && pstrb[3] &&
                                   pwdata[`DCC_ABORT_BIT];
            assign launch_cmd[g] = ctrl_hit[g] && pstrb[3] &&
                                   pwdata[`DCC_LAUNCH_BIT];
            assign pause_cmd[g]  = ctrl_hit[g] && pstrb[3] &&
                                   pwdata[`DCC_PAUSE_BIT];
            assign irq_clr[g]    = wr_en && pstrb[0] && page_ok &&
                                   (offs == `DCC_IRQ_CLR_OFF) && pwdata[g];
            // Busy falls on any kind of completion.
            assign finish_evt[g] = active[g] &&
                                   (abort_cmd[g] || transfer_finished[g] ||
                                    transfer_error[g] || pause_reached[g]);
            assign direct_style[g]        = style[g];
            assign vme_flush_on_fault[g]  = vflush[g];
            assign pcix_flush_on_fault[g] = pflush[g];
        end
    endgenerate

    // Control fields: written only through enabled byte lanes.
    always @(posedge clk_sys) begin : field_regs
        integer i;
        if (rst) begin
            style  <= 2'h0;
            vflush <= 2'h0;
            pflush <= 2'h0;
            vburst <= 6'h00;
            vback  <= 6'h00;
            pburst <= 6'h00;
            pback  <= 6'h00;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (ctrl_hit[i]) begin
                    if (pstrb[2]) begin
                        style[i]  <= pwdata[`DCC_STYLE_BIT];
                        vflush[i] <= pwdata[`DCC_VFLUSH_BIT];
                        pflush[i] <= pwdata[`DCC_PFLUSH_BIT];
                    end
                    if (pstrb[1]) begin
                        vburst[i*3 +: 3] <= pwdata[`DCC_VBURST_LSB +: 3];
                        vback[i*3 +: 3]  <= pwdata[`DCC_VBACK_LSB +: 3];
                    end
                    if (pstrb[0]) begin
                        pburst[i*3 +: 3] <= pwdata[`DCC_PBURST_LSB +: 3];
                        pback[i*3 +: 3]  <= pwdata[`DCC_PBACK_LSB +: 3];
                    end
                end
            end
        end
    end

    // Channel sequencing. Abort outranks pause and completion; an error
    // arriving in the same cycle as an abort reports error and done, without the abort flag.
    always @(posedge clk_sys) begin : channel_seq
        integer i;
        if (rst) begin
            active          <= 2'h0;
            done            <= 2'h0;
            err             <= 2'h0;
            aborted         <= 2'h0;
            paused          <= 2'h0;
            master_start    <= 2'h0;
            master_halt     <= 2'h0;
            fifo_invalidate <= 2'h0;
            pause_command   <= 2'h0;
        end else begin
            master_start    <= 2'h0;
            master_halt     <= 2'h0;
            fifo_invalidate <= 2'h0;
            for (i = 0; i < 2; i = i + 1) begin
                if (active[i] && abort_cmd[i]) begin
                    master_halt[i]     <= 1'b1;
                    fifo_invalidate[i] <= 1'b1;
                    active[i]          <= 1'b0;
                    done[i]            <= 1'b1;
                    err[i]             <= 1'b1;
                    aborted[i]         <= !transfer_error[i];
                    pause_command[i]   <= 1'b0;
                end else if (active[i] && transfer_error[i]) begin
                    active[i]        <= 1'b0;
                    err[i]           <= 1'b1;
                    pause_command[i] <= 1'b0;
                end else if (active[i] && pause_reached[i]) begin
                    active[i]        <= 1'b0;
                    paused[i]        <= 1'b1;
                    pause_command[i] <= 1'b0;
                end else if (active[i] && transfer_finished[i]) begin
                    active[i] <= 1'b0;
                    done[i]   <= 1'b1;
                end else if (!active[i] && launch_cmd[i]) begin
                    active[i]       <= 1'b1;
                    done[i]         <= 1'b0;
                    err[i]          <= 1'b0;
                    aborted[i]      <= 1'b0;
                    paused[i]       <= 1'b0;
                    master_start[i] <= 1'b1;
                end else if (active[i] && pause_cmd[i] && !style[i]) begin
                    // Pause applies only to descriptor-list transfers.
                    pause_command[i] <= 1'b1;
                end
            end
        end
    end

    // burst size decode, 32 bytes doubled per code
    always @(posedge clk_sys) begin : burst_decode
        integer i;
        if (rst) begin
            burst_bytes <= 26'h0000000;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                burst_bytes[i*13 +: 13] <= source_is_vme[i] ?
                    (`DCC_BURST_BASE << vburst[i*3 +: 3]) :
                    (`DCC_BURST_BASE << pburst[i*3 +: 3]);
            end
        end
    end

    // Microsecond tick shared by both back-off timers.
    reg  [15:0] us_cnt;
    wire        us_tick;
    assign us_tick = (us_cnt == CYC_PER_US[15:0] - 16'h0001);
    always @(posedge clk_sys) begin
        if (rst || us_tick) begin
            us_cnt <= 16'h0000;
        end else begin
            us_cnt <= us_cnt + 16'h0001;
        end
    end

    // back-off timers count microseconds after each block request.
    // One process per kind keeps each vector on a single driver.
    reg  [13:0] back_left;
    reg  [13:0] back_us;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_back
            assign backoff_expired[g] = (back_left[g*7 +: 7] == 7'h00);
        end
    endgenerate
    // Code 0 means no wait; code n waits 2^(n-1) microseconds.
    always @* begin : back_decode
        integer   j;
        reg [2:0] sel_code;
        j        = 0;
        sel_code = 3'h0;
        back_us  = 14'h0000;
        for (j = 0; j < 2; j = j + 1) begin
            sel_code = source_is_vme[j] ? vback[j*3 +: 3] : pback[j*3 +: 3];
            if (sel_code != 3'h0) begin
                back_us[j*7 +: 7] = 7'h01 << (sel_code - 3'h1);
            end
        end
    end
    // A new block request reloads the wait; an idle channel holds zero.
    always @(posedge clk_sys) begin : back_count
        integer k;
        for (k = 0; k < 2; k = k + 1) begin
            if (rst || !active[k]) begin
                back_left[k*7 +: 7] <= 7'h00;
            end else if (block_request[k]) begin
                back_left[k*7 +: 7] <= back_us[k*7 +: 7];
            end else if (us_tick && !backoff_expired[k]) begin
                back_left[k*7 +: 7] <= back_left[k*7 +: 7] - 7'h01;
            end
        end
    end

    // Interrupt status: completion sets, clear register clears, set wins.
    always @(posedge clk_sys) begin
        if (rst) begin
            irq_stat <= 2'h0;
            irq_en   <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | finish_evt;
            if (wr_en && pstrb[0] && page_ok &&
                (offs == `DCC_IRQ_EN_OFF)) begin
                irq_en <= pwdata[1:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_en);

    // Read views; command bits and reserved bits are left zero.
    always @* begin : read_views
        integer i;
        i = 0;
        for (i = 0; i < 2; i = i + 1) begin
            ctrl_view[i] = 32'h00000000;
            ctrl_view[i][`DCC_ABORT_BIT]  = 1'b0;
            ctrl_view[i][`DCC_LAUNCH_BIT] = 1'b0;
            ctrl_view[i][`DCC_STYLE_BIT]  = style[i];
            ctrl_view[i][`DCC_VFLUSH_BIT] = vflush[i];
            ctrl_view[i][`DCC_PFLUSH_BIT] = pflush[i];
            ctrl_view[i][`DCC_VBURST_LSB +: 3] = vburst[i*3 +: 3];
            ctrl_view[i][`DCC_VBACK_LSB +: 3]  = vback[i*3 +: 3];
            ctrl_view[i][`DCC_PBURST_LSB +: 3] = pburst[i*3 +: 3];
            ctrl_view[i][`DCC_PBACK_LSB +: 3]  = pback[i*3 +: 3];
            stat_view[i] = 32'h00000000;
            stat_view[i][`DCC_ST_ERR_BIT]    = err[i];
            stat_view[i][`DCC_ST_ABORT_BIT]  = aborted[i];
            stat_view[i][`DCC_ST_PAUSE_BIT]  = paused[i];
            stat_view[i][`DCC_ST_DONE_BIT]   = done[i];
            stat_view[i][`DCC_ST_ACTIVE_BIT] = active[i];
        end
    end

    // Read data is registered during setup so it is valid in the access.
    always @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite && !page_ok) begin
            // Reads outside the register page return zero.
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr[11:0])
                `DCC_CTRL0_OFF:    prdata <= ctrl_view[0];
                `DCC_CTRL1_OFF:    prdata <= ctrl_view[1];
                `DCC_STAT0_OFF:    prdata <= stat_view[0];
                `DCC_STAT1_OFF:    prdata <= stat_view[1];
                `DCC_IRQ_STAT_OFF: prdata <= {30'h00000000, irq_stat};
                `DCC_IRQ_EN_OFF:   prdata <= {30'h00000000, irq_en};
                default:           prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // dcc_channel_control
`default_nettype wire

// ===== testbench/dcc_ctrl_chk.sv
// Port checker for channel 0 of the DMA channel control block.
`timescale 1ns/100ps
`default_nettype none
module dcc_ctrl_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic [1:0]  master_start,
    input wire logic [1:0]  master_halt,
    input wire logic [1:0]  fifo_invalidate,
    input wire logic [1:0]  direct_style,
    input wire logic [1:0]  vme_flush_on_fault,
    input wire logic [1:0]  pcix_flush_on_fault
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Completed write to the channel 0 control word.
    wire logic w0 = psel && penable && pwrite && paddr == 32'h0000_0500;
    // Command writes; the top byte lane must be enabled.
    wire logic go0 = w0 && pstrb[3] && pwdata[25];
    wire logic kill0 = w0 && pstrb[3] && pwdata[27];
    sequence s_rd0;
        psel && !penable && !pwrite && paddr == 32'h0000_0500;
    endsequence
    sequence s_cfg0;
        w0 && pstrb[2];
    endsequence
    a_start_cause: assert property (
        master_start[0] |-> $past(go0)) else $error("start without launch");
    a_start_single: assert property (
        master_start[0] |=> !master_start[0]) else $error("start too long");
    a_halt_cause: assert property (
        master_halt[0] |-> $past(kill0)) else $error("halt without abort");
    a_halt_flush: assert property (
        master_halt[0] |-> fifo_invalidate[0] ##1 !master_halt[0])
        else $error("halt without fifo flush");
    a_cmd_rd_zero: assert property (
        s_rd0 |=> prdata[27:25] == 3'h0) else $error("command bits read");
    a_rsvd_rd_zero: assert property (
        s_rd0 |=> (prdata & 32'hF17C_8888) == 32'h0)
        else $error("reserved bits read");
    a_flush_follow: assert property (
        s_cfg0 |=> vme_flush_on_fault[0] == $past(pwdata[17])
            && pcix_flush_on_fault[0] == $past(pwdata[16]))
        else $error("flush setting lost");
    a_style_follow: assert property (
        s_cfg0 |=> direct_style[0] == $past(pwdata[23]))
        else $error("style setting lost");
endmodule // dcc_ctrl_chk
bind dcc_channel_control dcc_ctrl_chk u_dcc_ctrl_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .master_start(master_start),
    .master_halt(master_halt), .fifo_invalidate(fifo_invalidate),
    .direct_style(direct_style), .vme_flush_on_fault(vme_flush_on_fault),
    .pcix_flush_on_fault(pcix_flush_on_fault));
`default_nettype wire

// ===== testbench/dcc_engine_model.sv
// Far-side engine model: finishes each launch after LAT cycles unless a halt comes first.
`timescale 1ns/100ps
`default_nettype none
module dcc_engine_model #(
    parameter int LAT = 40  // Cycles from launch to finish.
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] master_start,
    input  wire logic [1:0] master_halt,
    output logic      [1:0] block_request = 2'h0,
    output logic      [1:0] transfer_finished = 2'h0
);
    int cnt [2] = '{0, 0};  // Cycles left per channel, zero when idle.
    // A halt clears the count, so no finish follows it unless the count was already at one.
    always @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            block_request[i] <= master_start[i];
            transfer_finished[i] <= cnt[i] == 1;
            if (rst || master_halt[i]) begin
                cnt[i] <= 0;
            end else if (master_start[i]) begin
                cnt[i] <= LAT;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule // dcc_engine_model
`default_nettype wire

// ===== testbench/dcc_channel_control_tb.sv
// Self-checking bench for the two-channel DMA control block.
`timescale 1ns/100ps
`default_nettype none
module dcc_channel_control_tb;
    logic        clk_sys = 1'b0;  // Core clock, 4 ns period.
    logic        rst = 1'b1;      // Held for the first five edges.
    logic        psel = 1'b0;     // APB request lines.
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        last_err;        // Error flag of the last transfer.
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;         // Cycle count for the timeout.
    wire         pready, pslverr, irq;
    wire  [31:0] prdata;
    wire  [25:0] burst_bytes;
    wire  [1:0]  master_start, master_halt, fifo_invalidate, direct_style;
    wire  [1:0]  vme_flush_on_fault, pcix_flush_on_fault, backoff_expired;
    wire  [1:0]  block_request, transfer_finished, pause_command;
    dcc_channel_control #(.CYC_PER_US(4)) u_dcc_channel_control (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .master_start(master_start), .master_halt(master_halt),
        .fifo_invalidate(fifo_invalidate), .direct_style(direct_style),
        .vme_flush_on_fault(vme_flush_on_fault),
        .pcix_flush_on_fault(pcix_flush_on_fault),
        .burst_bytes(burst_bytes), .backoff_expired(backoff_expired),
        .block_request(block_request), .source_is_vme(2'b10),
        .transfer_finished(transfer_finished), .transfer_error(2'b00),
        .pause_reached(2'b00), .pause_command(pause_command), .irq(irq));
    dcc_engine_model #(.LAT(40)) u_dcc_engine_model (
        .clk_sys(clk_sys), .rst(rst), .master_start(master_start),
        .master_halt(master_halt), .block_request(block_request),
        .transfer_finished(transfer_finished));
    // Free-running clock.
    initial forever #2 clk_sys = ~clk_sys;
    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; pready is polled, though this slave always holds it high.
    task automatic apb(input logic w, input logic [31:0] a, d,
                       input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
        logic [31:0] q;
        apb(1'b1, a, d, s, q);
    endtask
    task automatic rdc(input logic [31:0] a, e, input string nm);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, 4'h0, q);
        chk(nm, q, e);
    endtask
    // Reset values, field access and an unmapped address.
    task automatic t_regs();
        rdc(32'h500, 32'h0, "ctrl0 reset");
        rdc(32'h580, 32'h0, "ctrl1 reset");
        chk("backoff idle", 32'(backoff_expired), 32'h3);
        chk("ready", 32'(pready), 32'h1);
        rdc(32'h510, 32'h0, "unmapped");
        chk("unmapped err", 32'(last_err), 32'h1);
        for (logic [31:0] a = 32'h500; a <= 32'h580; a += 32'h80) begin
            wr(a, 32'hFFFF_FFFF, 4'h7);
            rdc(a, 32'h0083_7777, "ctrl rw");
        end
        chk("levels", 32'({direct_style, vme_flush_on_fault,
            pcix_flush_on_fault}), 32'h3F);
    endtask
    // Every burst code on the PCI/X side of 0 and VME side of 1.
    task automatic t_burst();
        for (int k = 0; k < 8; k++) begin
            wr(32'h500, 32'(k) << 4, 4'h1);
            wr(32'h580, 32'(k) << 12, 4'h2);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("burst0", 32'(burst_bytes[12:0]), 32'h20 << k);
            chk("burst1", 32'(burst_bytes[25:13]), 32'h20 << k);
        end
    endtask
    // Abort in mid-transfer; the transfer must never resume.
    task automatic t_abort();
        wr(32'h500, 32'h0200_0000, 4'hF);
        #1;
        chk("start0", 32'(master_start), 32'h1);
        rdc(32'h500, 32'h0, "launch reads");
        wr(32'h500, 32'h0400_0000, 4'hF);
        #1;
        chk("list pause", 32'(pause_command), 32'h1);
        wr(32'h500, 32'h0800_0000, 4'hF);
        #1;
        chk("halt", 32'({master_halt, fifo_invalidate}), 32'h5);
        chk("pause dropped", 32'(pause_command), 32'h0);
        rdc(32'h500, 32'h0, "abort reads");
        rdc(32'h504, 32'h1A00_0000, "stat0 abort");
        repeat (60) @(posedge clk_sys);
        rdc(32'h504, 32'h1A00_0000, "stat0 later");
    endtask
    // Normal finish on channel 1, interrupt mask and clear, idle abort.
    task automatic t_done();
        wr(32'h580, 32'h0280_0300, 4'hF);
        #1;
        chk("start1", 32'(master_start), 32'h2);
        // Code 3 waits 4 us of 4 cycles, less up to one tick of jitter.
        repeat (14) @(posedge clk_sys);
        #1;
        chk("backoff wait", 32'(backoff_expired[1]), 32'h0);
        repeat (4) @(posedge clk_sys);
        #1;
        chk("backoff over", 32'(backoff_expired[1]), 32'h1);
        wr(32'h580, 32'h0480_0000, 4'hF);
        #1;
        chk("direct pause", 32'(pause_command), 32'h0);
        repeat (40) @(posedge clk_sys);
        rdc(32'h584, 32'h0200_0000, "stat1 done");
        rdc(32'h600, 32'h3, "irq status");
        chk("irq masked", 32'(irq), 32'h0);
        wr(32'h604, 32'h2, 4'hF);
        #1;
        chk("irq raised", 32'(irq), 32'h1);
        wr(32'h608, 32'h2, 4'hF);
        #1;
        chk("irq cleared", 32'(irq), 32'h0);
        wr(32'h580, 32'h0800_0000, 4'hF);
        #1;
        chk("idle abort", 32'(master_halt), 32'h0);
        rdc(32'h584, 32'h0200_0000, "stat1 kept");
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_burst();
        t_abort();
        t_done();
        conclude();
    end
endmodule // dcc_channel_control_tb
`default_nettype wire
